// File: core/itame_exec.sv
// Execution logic of the two-word indexed-to-absolute data move
// Operation
// - Recognise first word 1110 1011 0 plus offset, then second word 1111 plus address.
// - Source address is index pointer two plus the unsigned seven-bit offset.
// - Destination address is the twelve-bit literal of the second word, unmodified.
// - Both addresses span the whole 4096-byte data space, 000h to FFFh.
// - Copy the source byte unchanged; arithmetic status flags stay untouched.
// - Source in an indirect-addressing register reads as zero, no indirect access.
// - Cycle one: compute source address in Q2 and Q3, read in Q4.
// - Cycle two: no dummy read, write held byte to destination in Q4.
`timescale 1ns/1ps
`include "itame_regs.svh"

module itame_exec (
  input  wire logic                    ref_clk_in,        // Core clock, 125 MHz
  input  wire logic                    rst_n_in,          // Synchronous reset, active low
  input  wire itame_pkg::itame_fetch_t fetch_in,          // Instruction word, sampled in Q1
  input  wire logic [11:0]             index_pointer_two_in, // Index pointer two contents
  input  wire logic [7:0]              rd_data_in,        // Data memory read data, same cycle
  output itame_pkg::itame_rd_t         rd_out,            // Data memory read request
  output itame_pkg::itame_wr_t         wr_out,            // Data memory write request
  output logic [1:0]                   quarter_out,       // Current quarter phase
  output logic                         busy_out,          // Move in progress
  output logic                         done_out           // Pulse after destination write
);

  itame_pkg::itame_state_t state_reg;
  itame_pkg::itame_state_t state_next;
  logic [1:0]  quarter_reg;
  logic [6:0]  offset_reg;
  logic [11:0] src_addr_reg;
  logic [11:0] dest_reg;
  logic [7:0]  hold_reg;
  itame_pkg::itame_rd_t rd_reg;
  itame_pkg::itame_wr_t wr_reg;
  logic        busy_reg;
  logic        done_reg;

  wire   in_q1 = (quarter_reg == `ITAME_Q1);
  wire   in_q3 = (quarter_reg == `ITAME_Q3);
  wire   in_q4 = (quarter_reg == `ITAME_Q4);

  wire   first_hit = fetch_in.valid &&
                     (fetch_in.word[`ITAME_OP1_TAG_MSB:`ITAME_OP1_TAG_LSB] == `ITAME_OP1_TAG);
  wire   second_hit = fetch_in.valid &&
                      (fetch_in.word[`ITAME_OP2_TAG_MSB:`ITAME_OP2_TAG_LSB] == `ITAME_OP2_TAG);

  // Twelve-bit sum wraps inside the data space
  wire   [11:0] src_sum = 12'(index_pointer_two_in + {5'h00, offset_reg});

  // Indirect-addressing register windows, checked on the held and on the live sum
  wire   [2:0]  win_hit_cur;
  wire   [2:0]  win_hit_pre;
  genvar        gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_win
      localparam logic [11:0] win_base = (gi == 0) ? `ITAME_IND_BASE0 :
                                         (gi == 1) ? `ITAME_IND_BASE1 : `ITAME_IND_BASE2;
      wire [11:0] off_cur = 12'(src_addr_reg - win_base);
      wire [11:0] off_pre = 12'(src_sum - win_base);
      assign win_hit_cur[gi] = (off_cur < `ITAME_IND_SPAN);
      assign win_hit_pre[gi] = (off_pre < `ITAME_IND_SPAN);
    end
  endgenerate
  wire   src_indirect     = |win_hit_cur;
  wire   src_indirect_pre = |win_hit_pre;

  wire   [7:0] src_byte = src_indirect ? `ITAME_INDIRECT_VAL : rd_data_in;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      itame_pkg::ITAME_IDLE: begin
        if (in_q1 && first_hit) begin
          state_next = itame_pkg::ITAME_CYC1;
        end
      end
      itame_pkg::ITAME_CYC1: begin
        if (in_q4) begin
          state_next = itame_pkg::ITAME_CYC2;
        end
      end
      itame_pkg::ITAME_CYC2: begin
        // A missing second word abandons the move without writing
        if ((in_q1 && !second_hit) || in_q4) begin
          state_next = itame_pkg::ITAME_IDLE;
        end
      end
      default: begin
        state_next = itame_pkg::ITAME_IDLE;
      end
    endcase
  end

  wire   cyc1 = (state_reg == itame_pkg::ITAME_CYC1);
  wire   cyc2 = (state_reg == itame_pkg::ITAME_CYC2);

  // Read visible in Q4 of cycle one; indirect sources never reach the memory
  wire   rd_en_next = cyc1 && in_q3 && !src_indirect_pre;
  // Write visible in Q4 of cycle two only; no read is issued in cycle two
  wire   wr_en_next = cyc2 && in_q3;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      quarter_reg <= `ITAME_Q1;
      state_reg   <= itame_pkg::ITAME_IDLE;
    end else begin
      quarter_reg <= 2'(quarter_reg + 2'h1);
      state_reg   <= state_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      offset_reg   <= 7'h00;
      src_addr_reg <= 12'h000;
      dest_reg     <= 12'h000;
    end else begin
      if (state_reg == itame_pkg::ITAME_IDLE && in_q1 && first_hit) begin
        offset_reg <= fetch_in.word[`ITAME_OFFSET_MSB:0];
      end
      if (cyc1 && (quarter_reg == `ITAME_Q2 || in_q3)) begin
        src_addr_reg <= src_sum;
      end
      if (cyc2 && in_q1 && second_hit) begin
        dest_reg <= fetch_in.word[`ITAME_DEST_MSB:0];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      hold_reg <= 8'h00;
    end else if (cyc1 && in_q4) begin
      hold_reg <= src_byte;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rd_reg   <= '0;
      wr_reg   <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      rd_reg.en   <= rd_en_next;
      rd_reg.addr <= src_sum;
      wr_reg.en   <= wr_en_next;
      wr_reg.addr <= dest_reg;
      wr_reg.data <= hold_reg;
      busy_reg    <= (state_next != itame_pkg::ITAME_IDLE);
      done_reg    <= cyc2 && in_q4;
    end
  end

  assign rd_out      = rd_reg;
  assign wr_out      = wr_reg;
  assign quarter_out = quarter_reg;
  assign busy_out    = busy_reg;
  assign done_out    = done_reg;

endmodule // itame_exec

// File: core/itame_regs.svh
// Constants for the indexed-to-absolute move execution block
`ifndef ITAME_REGS_SVH
`define ITAME_REGS_SVH

// First word: top nine bits, second word: top four bits
`define ITAME_OP1_TAG      9'h1d6
`define ITAME_OP1_TAG_MSB  15
`define ITAME_OP1_TAG_LSB  7
`define ITAME_OFFSET_MSB   6
`define ITAME_OP2_TAG      4'hf
`define ITAME_OP2_TAG_MSB  15
`define ITAME_OP2_TAG_LSB  12
`define ITAME_DEST_MSB     11

// Quarter phase encodings of the phase counter
`define ITAME_Q1           2'h0
`define ITAME_Q2           2'h1
`define ITAME_Q3           2'h2
`define ITAME_Q4           2'h3

// Byte returned when the source is an indirect-addressing register
`define ITAME_INDIRECT_VAL 8'h00

// Indirect-addressing register windows: three groups of five addresses
`define ITAME_IND_BASE0    12'hfeb
`define ITAME_IND_BASE1    12'hfe3
`define ITAME_IND_BASE2    12'hfdb
`define ITAME_IND_SPAN     12'h005

`endif

// File: core/itame_pkg.sv
// Types for the indexed-to-absolute move execution block
package itame_pkg;

  typedef enum logic [1:0] {
    ITAME_IDLE,
    ITAME_CYC1,
    ITAME_CYC2
  } itame_state_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } itame_fetch_t;

  typedef struct packed {
    logic        en;
    logic [11:0] addr;
  } itame_rd_t;

  typedef struct packed {
    logic        en;
    logic [11:0] addr;
    logic [7:0]  data;
  } itame_wr_t;

endpackage

// File: bench/itame_exec_assertions.sv
// Checker for the indexed-to-absolute move block
`timescale 1ns/1ps
module itame_exec_chk (
  input wire logic                    ref_clk_in,           // Clock
  input wire logic                    rst_n_in,             // Reset
  input wire itame_pkg::itame_fetch_t fetch_in,             // Fetch
  input wire logic [11:0]             index_pointer_two_in, // Pointer
  input wire logic [7:0]              rd_data_in,           // Read data
  input wire itame_pkg::itame_rd_t    rd_out,               // Read
  input wire itame_pkg::itame_wr_t    wr_out,               // Write
  input wire logic [1:0]              quarter_out,          // Quarter
  input wire logic                    busy_out,             // Busy
  input wire logic                    done_out              // Done
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_first; fetch_in.valid && fetch_in.word[15:7] == 9'h1d6 && quarter_out == 2'h0 && !busy_out; endsequence
  sequence s_second; fetch_in.valid && fetch_in.word[15:12] == 4'hf; endsequence
  property p_rd; rd_out.en |-> quarter_out == 2'h3; endproperty
  a_rd: assert property (p_rd) else $error("read outside Q4");
  property p_src; rd_out.en |-> rd_out.addr == $past(index_pointer_two_in) + 12'($past(fetch_in.word[6:0], 3)); endproperty
  a_src: assert property (p_src) else $error("bad source address");
  property p_dst; wr_out.en |-> wr_out.addr == $past(fetch_in.word[11:0], 3); endproperty
  a_dst: assert property (p_dst) else $error("bad destination");
  property p_copy; (rd_out.en ##4 wr_out.en) |-> wr_out.data == $past(rd_data_in, 4); endproperty
  a_copy: assert property (p_copy) else $error("byte changed");
  property p_ind; wr_out.en && !$past(rd_out.en, 4) |-> wr_out.data == 8'h00; endproperty
  a_ind: assert property (p_ind) else $error("unread byte not zero");
  property p_seq; (s_first ##4 s_second) |=> busy_out [*2] ##1 (wr_out.en && quarter_out == 2'h3) ##1 (done_out && !busy_out); endproperty
  a_seq: assert property (p_seq) else $error("bad move sequence");
  property p_dummy; rd_out.en |=> !rd_out.en [*7]; endproperty
  a_dummy: assert property (p_dummy) else $error("dummy read");
  property p_ign; fetch_in.valid && fetch_in.word[15:7] != 9'h1d6 && quarter_out == 2'h0 && !busy_out |=> !busy_out; endproperty
  a_ign: assert property (p_ign) else $error("wrong word taken");
endmodule // itame_exec_chk
bind itame_exec itame_exec_chk u_chk (.*);

// File: bench/itame_mem.sv
// Data memory model on the block's read and write ports
`timescale 1ns/1ps
module itame_mem (
  input  wire logic                 clk_in,  // Clock
  input  wire itame_pkg::itame_rd_t rd_in,   // Read
  input  wire itame_pkg::itame_wr_t wr_in,   // Write
  output logic [7:0]                data_out // Read data
);
  logic [7:0] mem [4096];
  logic [7:0] last_reg = 8'h00;
  initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h3c;
  // Unselected reads show the inverse of the last answer
  assign data_out = rd_in.en ? mem[rd_in.addr] : ~last_reg;
  always @(posedge clk_in) begin
    if (rd_in.en) last_reg <= mem[rd_in.addr];
    if (wr_in.en) mem[wr_in.addr] <= wr_in.data;
  end
endmodule // itame_mem

// File: bench/itame_exec_tb_top.sv
// Self-checking bench for the indexed-to-absolute move block
`timescale 1ns/1ps
module itame_exec_tb_top;
  logic                    ref_clk_in = 1'b0;
  logic                    rst_n_in = 1'b0;
  itame_pkg::itame_fetch_t fetch_in = '0;
  logic [11:0]             index_pointer_two_in = '0;
  logic [7:0]              rd_data_in;
  itame_pkg::itame_rd_t    rd_out;
  itame_pkg::itame_wr_t    wr_out;
  logic [1:0]              quarter_out;
  logic                    busy_out, done_out;
  int                      mismatches = 0, comparisons = 0, cyc = 0;
  itame_exec DUT (.*);
  itame_mem u_mem (.clk_in(ref_clk_in), .rd_in(rd_out), .wr_in(wr_out), .data_out(rd_data_in));
  initial forever #4 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) if (++cyc == 1000) begin mismatches++; finish_test(); end
  task automatic chk(input logic [11:0] s, x);
    comparisons++;
    if (s !== x) begin mismatches++; $display("[ERR] %0t got %h want %h", $time, s, x); end
  endtask
  task automatic step(input int n); repeat (n) @(posedge ref_clk_in) #1; endtask
  task automatic mv(input logic [15:0] w, input logic [11:0] p, d, input logic [7:0] e, input logic r);
    while (quarter_out !== 2'h0) step(1);
    fetch_in = {1'b1, w}; index_pointer_two_in = p;
    step(1); fetch_in.valid = 1'b0;
    step(2); chk(rd_out.en, r);
    if (r) chk(rd_out.addr, p + w[6:0]);
    step(1); fetch_in = {1'b1, 4'hf, d}; // destination never a stack or counter byte
    step(1); fetch_in.valid = 1'b0;
    step(2); chk(wr_out.en, 1'b1); chk(wr_out.addr, d); chk(wr_out.data, e);
    chk(quarter_out, 12'h003);
    step(1); chk(done_out, 1'b1); chk(wr_out.en, 1'b0);
  endtask
  task automatic t_basic;
    mv(16'heb05, 12'h080, 12'h0a2, 8'h85 ^ 8'h3c, 1'b1);
    mv(16'heb7f, 12'h001, 12'h100, 8'h80 ^ 8'h3c, 1'b1);
    $display("basic and back-to-back done");
  endtask
  task automatic t_edge;
    mv(16'heb7f, 12'hf80, 12'h000, 8'hff ^ 8'h3c, 1'b1);
    mv(16'heb00, 12'h000, 12'hfff, 8'hff ^ 8'h3c, 1'b1);
    $display("address edges done");
  endtask
  task automatic t_ind;
    mv(16'heb0b, 12'hfe0, 12'h200, 8'h00, 1'b0);
    $display("indirect source done");
  endtask
  task automatic t_bad;
    while (quarter_out !== 2'h0) step(1);
    fetch_in = {1'b1, 16'heb85};
    step(1); fetch_in.valid = 1'b0;
    step(3); chk(busy_out, 1'b0); chk(rd_out.en, 1'b0);
    while (quarter_out !== 2'h0) step(1);
    fetch_in = {1'b1, 16'heb05};
    step(1); fetch_in.valid = 1'b0;
    step(6); chk(wr_out.en, 1'b0); chk(busy_out, 1'b0); // missing second word aborts
    step(1); chk(done_out, 1'b0);
    $display("foreign word done");
  endtask
  task automatic finish_test;
    $display("counts: %0d mismatches, %0d comparisons", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    step(6); rst_n_in = 1'b1;
    t_basic(); t_edge(); t_ind(); t_bad();
    finish_test();
  end
endmodule // itame_exec_tb_top
